// file: nco_clk_sel.sv
// Purpose: Synchronises the input clock sources and emits edge ticks
// Assumes: Sources hold each level for at least two hclk cycles to be seen fully
// Notes:   System clock choice ticks on every hclk cycle
`timescale 1ns/1ps
module nco_clk_sel
  import nco_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic internal_fast_oscillator,
  input  wire logic logic_cell_one_output,
  input  wire logic external_clock_pin,
  nco_tick_if.src   tick_port
);

  logic [2:0] raw_in;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] filt_reg;
  logic [2:0] rise;
  logic       tick_reg;

  assign raw_in = {external_clock_pin, logic_cell_one_output, internal_fast_oscillator};

  // Three-stage synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Level accepted once the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_reg <= 3'h0;
    end else begin
      filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
    end
  end

  assign rise = sync2_reg & sync3_reg & ~filt_reg;

  // Source selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reg <= 1'b0;
    end else begin
      case (tick_port.sel)
        CKS_FAST_OSC: tick_reg <= rise[0];
        CKS_SYSTEM:   tick_reg <= 1'b1;
        CKS_LOGIC:    tick_reg <= rise[1];
        CKS_EXT_PIN:  tick_reg <= rise[2];
        default:      tick_reg <= 1'b0;
      endcase
    end
  end

  assign tick_port.tick = tick_reg;

endmodule : nco_clk_sel

// file: nco_pkg.sv
// Purpose: Shared constants and types of the oscillator block
// Assumes: Byte-wide registers, each on its own aligned 32-bit word
// Notes:   Offsets decode on the low eight address bits
package nco_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_CLKSEL    = 8'h04;
  localparam logic [7:0] OFF_ACC_LOW   = 8'h08;
  localparam logic [7:0] OFF_ACC_HIGH  = 8'h0c;
  localparam logic [7:0] OFF_ACC_UPPER = 8'h10;
  localparam logic [7:0] OFF_INC_LOW   = 8'h14;
  localparam logic [7:0] OFF_INC_HIGH  = 8'h18;

  // Control register fields
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_OE_BIT   = 6;
  localparam int CTRL_OUT_BIT  = 5;
  localparam int CTRL_POL_BIT  = 4;
  localparam int CTRL_PFM_BIT  = 0;

  // Clock select register fields
  localparam int CLK_PWS_MSB   = 7;
  localparam int CLK_PWS_LSB   = 5;
  localparam int CLK_CKS_MSB   = 1;
  localparam int CLK_CKS_LSB   = 0;

  // Widths
  localparam int ACC_W         = 20;
  localparam int INC_W         = 16;

  // Reset values
  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [7:0]       CLKSEL_RST = 8'h00;
  localparam logic [ACC_W-1:0] ACC_RST    = 20'h00000;
  localparam logic [7:0]       INC_LOW_RST  = 8'h01;
  localparam logic [7:0]       INC_HIGH_RST = 8'h00;
  localparam logic [INC_W-1:0] INC_BUF_RST  = 16'h0001;

  // Input clock edges from a low byte write to the buffer load
  localparam logic [1:0] LOAD_TICKS = 2'h2;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Input clock sources
  typedef enum logic [1:0] {
    CKS_FAST_OSC = 2'h0,
    CKS_SYSTEM   = 2'h1,
    CKS_LOGIC    = 2'h2,
    CKS_EXT_PIN  = 2'h3
  } nco_cks_t;

endpackage : nco_pkg

// file: nco_tick_if.sv
// Purpose: Carries clock choice and input clock ticks between modules
// Assumes: Single hclk domain
// Notes:   Tick is a one-cycle enable
`timescale 1ns/1ps
interface nco_tick_if;
  import nco_pkg::*;
  nco_cks_t sel;
  logic     tick;
  modport src  (input sel, output tick);
  modport user (output sel, input tick);
endinterface : nco_tick_if

// file: nco_top.sv
// Purpose: Numerically controlled oscillator with AHB-Lite registers
// Assumes: One hclk domain, input clock seen as one-cycle ticks
// Notes:   Zero wait states, response always OKAY
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module nco_top
  import nco_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        internal_fast_oscillator,
  input  wire logic        logic_cell_one_output,
  input  wire logic        external_clock_pin,
  output logic             osc_out,
  output logic             osc_pin_out,
  output logic             osc_pin_oe,
  output logic             overflow_irq_req
);

  logic [31:0]      hrdata_reg;
  logic             hreadyout_reg;
  logic             hresp_reg;
  logic             wr_pend_reg;
  logic [7:0]       wr_addr_reg;
  logic             addr_ok;
  logic             rd_take;
  logic [7:0]       rd_byte;
  logic             ctrl_en_reg;
  logic             ctrl_oe_reg;
  logic             ctrl_pol_reg;
  logic             ctrl_pfm_reg;
  logic [2:0]       clk_pws_reg;
  logic [1:0]       clk_cks_reg;
  logic [ACC_W-1:0] acc_reg;
  logic [7:0]       inc_low_reg;
  logic [7:0]       inc_high_reg;
  logic [INC_W-1:0] inc_buf_reg;
  logic [1:0]       load_cnt_reg;
  logic             load_dis_reg;
  logic             load_now;
  logic             wr_ctrl;
  logic             wr_clksel;
  logic             wr_acc_low;
  logic             wr_acc_high;
  logic             wr_acc_upper;
  logic             wr_inc_low;
  logic             wr_inc_high;
  logic             acc_sw_wr;
  logic             run_tick;
  logic             adv;
  logic [ACC_W:0]   acc_sum_next;
  logic             carry;
  logic             toggle_reg;
  logic             ovf_pend_reg;
  logic             pulse_reg;
  logic [7:0]       pulse_cnt_reg;
  logic             raw_out;
  logic             out_level_next;
  logic             out_level_reg;
  logic             pin_out_reg;
  logic             pin_oe_reg;
  logic             irq_reg;

  // Pulse length minus one, in input clock periods
  function automatic logic [7:0] pulse_len_m1(input logic [2:0] pws);
    pulse_len_m1 = 8'((9'h001 << pws) - 9'h001);
  endfunction : pulse_len_m1

  nco_tick_if tick_bus ();
  assign tick_bus.sel = nco_cks_t'(clk_cks_reg);

  nco_clk_sel u_clk_sel (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .internal_fast_oscillator (internal_fast_oscillator),
    .logic_cell_one_output    (logic_cell_one_output),
    .external_clock_pin       (external_clock_pin),
    .tick_port                (tick_bus.src)
  );

  // Bus address phase
  assign addr_ok = hsel && (htrans == HTRANS_NONSEQ) && hready;
  assign rd_take = addr_ok && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  assign wr_ctrl      = wr_pend_reg && (wr_addr_reg == OFF_CTRL);
  assign wr_clksel    = wr_pend_reg && (wr_addr_reg == OFF_CLKSEL);
  assign wr_acc_low   = wr_pend_reg && (wr_addr_reg == OFF_ACC_LOW);
  assign wr_acc_high  = wr_pend_reg && (wr_addr_reg == OFF_ACC_HIGH);
  assign wr_acc_upper = wr_pend_reg && (wr_addr_reg == OFF_ACC_UPPER);
  assign wr_inc_low   = wr_pend_reg && (wr_addr_reg == OFF_INC_LOW);
  assign wr_inc_high  = wr_pend_reg && (wr_addr_reg == OFF_INC_HIGH);
  assign acc_sw_wr    = wr_acc_low || wr_acc_high || wr_acc_upper;

  // Read data mux, unmapped reads zero
  always_comb begin
    case (haddr[7:0])
      OFF_CTRL:      rd_byte = {ctrl_en_reg, ctrl_oe_reg, out_level_reg, ctrl_pol_reg, 3'h0, ctrl_pfm_reg};
      OFF_CLKSEL:    rd_byte = {clk_pws_reg, 3'h0, clk_cks_reg};
      OFF_ACC_LOW:   rd_byte = acc_reg[7:0];
      OFF_ACC_HIGH:  rd_byte = acc_reg[15:8];
      OFF_ACC_UPPER: rd_byte = {4'h0, acc_reg[19:16]};
      OFF_INC_LOW:   rd_byte = inc_low_reg;
      OFF_INC_HIGH:  rd_byte = inc_high_reg;
      default:       rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg    <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
      if (rd_take) begin
        hrdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  // Control and clock select registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_reg  <= CTRL_RST[CTRL_EN_BIT];
      ctrl_oe_reg  <= CTRL_RST[CTRL_OE_BIT];
      ctrl_pol_reg <= CTRL_RST[CTRL_POL_BIT];
      ctrl_pfm_reg <= CTRL_RST[CTRL_PFM_BIT];
      clk_pws_reg  <= CLKSEL_RST[CLK_PWS_MSB:CLK_PWS_LSB];
      clk_cks_reg  <= CLKSEL_RST[CLK_CKS_MSB:CLK_CKS_LSB];
    end else begin
      if (wr_ctrl) begin
        ctrl_en_reg  <= hwdata[CTRL_EN_BIT];
        ctrl_oe_reg  <= hwdata[CTRL_OE_BIT];
        ctrl_pol_reg <= hwdata[CTRL_POL_BIT];
        ctrl_pfm_reg <= hwdata[CTRL_PFM_BIT];
      end
      if (wr_clksel) begin
        clk_pws_reg <= hwdata[CLK_PWS_MSB:CLK_PWS_LSB];
        clk_cks_reg <= hwdata[CLK_CKS_MSB:CLK_CKS_LSB];
      end
    end
  end

  // Increment byte registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inc_low_reg  <= INC_LOW_RST;
      inc_high_reg <= INC_HIGH_RST;
    end else begin
      if (wr_inc_low) begin
        inc_low_reg <= hwdata[7:0];
      end
      if (wr_inc_high) begin
        inc_high_reg <= hwdata[7:0];
      end
    end
  end

  // Buffer load scheduling
  assign run_tick = tick_bus.tick && ctrl_en_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_cnt_reg <= 2'h0;
    end else if (!ctrl_en_reg) begin
      load_cnt_reg <= 2'h0;
    end else if (wr_inc_low) begin
      load_cnt_reg <= LOAD_TICKS;
    end else if (run_tick && (load_cnt_reg != 2'h0)) begin
      load_cnt_reg <= load_cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_dis_reg <= 1'b0;
    end else begin
      load_dis_reg <= !ctrl_en_reg && (wr_inc_low || wr_inc_high);
    end
  end

  assign load_now = load_dis_reg || (run_tick && (load_cnt_reg == 2'h1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inc_buf_reg <= INC_BUF_RST;
    end else if (load_now) begin
      inc_buf_reg <= {inc_high_reg, inc_low_reg};
    end
  end

  // Accumulator
  assign adv          = run_tick && !acc_sw_wr;
  assign acc_sum_next = {1'b0, acc_reg} + {5'h00, inc_buf_reg};
  assign carry        = adv && acc_sum_next[ACC_W];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= ACC_RST;
    end else if (wr_acc_low) begin
      acc_reg[7:0] <= hwdata[7:0];
    end else if (wr_acc_high) begin
      acc_reg[15:8] <= hwdata[7:0];
    end else if (wr_acc_upper) begin
      acc_reg[19:16] <= hwdata[3:0];
    end else if (adv) begin
      acc_reg <= acc_sum_next[ACC_W-1:0];
    end
  end

  // Toggle for fixed duty mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toggle_reg <= 1'b0;
    end else if (carry && !ctrl_pfm_reg) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  // Pulse generation for pulse mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_pend_reg <= 1'b0;
    end else if (!ctrl_en_reg || !ctrl_pfm_reg) begin
      ovf_pend_reg <= 1'b0;
    end else if (carry) begin
      ovf_pend_reg <= 1'b1;
    end else if (run_tick) begin
      ovf_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_reg     <= 1'b0;
      pulse_cnt_reg <= 8'h00;
    end else if (!ctrl_en_reg || !ctrl_pfm_reg) begin
      pulse_reg     <= 1'b0;
      pulse_cnt_reg <= 8'h00;
    end else if (run_tick && ovf_pend_reg) begin
      pulse_reg     <= 1'b1;
      pulse_cnt_reg <= pulse_len_m1(clk_pws_reg);
    end else if (run_tick && pulse_reg) begin
      if (pulse_cnt_reg == 8'h00) begin
        pulse_reg <= 1'b0;
      end else begin
        pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
      end
    end
  end

  // Output stage
  always_comb begin
    if (!ctrl_en_reg) begin
      raw_out = 1'b0;
    end else if (ctrl_pfm_reg) begin
      raw_out = pulse_reg;
    end else begin
      raw_out = toggle_reg;
    end
    out_level_next = raw_out ^ ctrl_pol_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_level_reg <= 1'b0;
      pin_out_reg   <= 1'b0;
      pin_oe_reg    <= 1'b0;
    end else begin
      out_level_reg <= out_level_next;
      pin_out_reg   <= out_level_next;
      pin_oe_reg    <= ctrl_oe_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= carry;
    end
  end

  assign hrdata           = hrdata_reg;
  assign hreadyout        = hreadyout_reg;
  assign hresp            = hresp_reg;
  assign osc_out          = out_level_reg;
  assign osc_pin_out      = pin_out_reg;
  assign osc_pin_oe       = pin_oe_reg;
  assign overflow_irq_req = irq_reg;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_hold_when_off: assert property (!ctrl_en_reg && !acc_sw_wr |=> $stable(acc_reg))
    else $error("accumulator moved while disabled");
  a_pin_enable_follow: assert property (wr_ctrl |=> ##1 (osc_pin_oe == $past(hwdata[CTRL_OE_BIT], 2)))
    else $error("pin enable does not follow control write");
  a_out_bit_read: assert property (rd_take && (haddr[7:0] == OFF_CTRL)
                                   |=> hrdata[CTRL_OUT_BIT] == $past(out_level_reg))
    else $error("output bit readback wrong");
  a_polarity_idle: assert property ($past(!ctrl_en_reg) |-> osc_out == $past(ctrl_pol_reg))
    else $error("idle level does not match polarity");
  a_reserved_zero: assert property (rd_take |=> (hrdata[31:8] == 24'h000000)
                                    && ($past(haddr[7:0]) != OFF_CTRL || hrdata[3:1] == 3'h0)
                                    && ($past(haddr[7:0]) != OFF_CLKSEL || hrdata[4:2] == 3'h0)
                                    && ($past(haddr[7:0]) != OFF_ACC_UPPER || hrdata[7:4] == 4'h0))
    else $error("reserved bits not zero");
  a_accum_add: assert property (adv |=> acc_reg == $past(acc_sum_next[ACC_W-1:0]))
    else $error("accumulator sum wrong");
  a_fdc_toggle: assert property (carry && !ctrl_pfm_reg && !wr_ctrl |=> ##1 (osc_out != $past(osc_out)))
    else $error("no toggle on carry");
  a_pulse_start: assert property (run_tick && ovf_pend_reg && ctrl_pfm_reg && !wr_ctrl
                                  |=> pulse_reg && pulse_cnt_reg == $past(pulse_len_m1(clk_pws_reg)))
    else $error("pulse did not start after carry");
  a_pulse_end: assert property (run_tick && pulse_reg && !ovf_pend_reg && pulse_cnt_reg == 8'h00 && !wr_ctrl
                                |=> !pulse_reg)
    else $error("pulse did not end");
  a_load_disabled: assert property (!ctrl_en_reg && wr_inc_low && !wr_ctrl
                                    |=> ##1 inc_buf_reg == {inc_high_reg, inc_low_reg})
    else $error("buffer not loaded while disabled");
  a_irq_single: assert property (carry |=> overflow_irq_req ##1 (!overflow_irq_req || $past(carry)))
    else $error("overflow request wrong");

  c_pulse_mode: cover property (ctrl_pfm_reg && pulse_reg ##1 !pulse_reg);
  c_fdc_toggle: cover property (carry && !ctrl_pfm_reg);
  c_load_enabled: cover property (ctrl_en_reg && load_now);
  c_irq_seen: cover property (overflow_irq_req);

endmodule : nco_top

// file: tb_top.sv
// Purpose: Self-checking bench for the oscillator block over AHB-Lite
// Assumes: Zero wait states, slow source clocks of 16 hclk periods
// Notes:   Outputs sampled at rising hclk edges
`timescale 1ns/1ps
module tb_top;
  import nco_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        osc_out;
  logic        osc_pin_out;
  logic        osc_pin_oe;
  logic        overflow_irq_req;
  logic [2:0]  src_run;
  logic [2:0]  src_lvl;
  logic [3:0]  src_cnt = 4'h0;
  logic [7:0]  offs [8];
  logic [7:0]  rst_v [8];
  logic [7:0]  one_v [8];
  int          fail_count;
  int          n_tests;
  int          i;
  int          n;

  nco_top DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .internal_fast_oscillator(src_lvl[0]),
    .logic_cell_one_output(src_lvl[1]), .external_clock_pin(src_lvl[2]),
    .osc_out(osc_out), .osc_pin_out(osc_pin_out), .osc_pin_oe(osc_pin_oe),
    .overflow_irq_req(overflow_irq_req)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Slow source clocks, 16 hclk periods
  always @(posedge hclk) begin
    src_cnt <= src_cnt + 4'h1;
    if (src_cnt[2:0] == 3'h7) begin
      src_lvl <= src_lvl ^ src_run;
    end
  end

  task results;
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : wait_ready

  task bus_cycle(input logic wr, input logic [7:0] addr, input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, addr};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_ready;
    rd = hrdata;
  endtask : bus_cycle

  task bus_write(input logic [7:0] addr, input logic [7:0] wd);
    logic [31:0] dummy;
    bus_cycle(1'b1, addr, wd, dummy);
  endtask : bus_write

  task rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [31:0] rd;
    bus_cycle(1'b0, addr, 8'h00, rd);
    check(what, rd, {24'h000000, exp});
    check("response", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : rd_chk

  function automatic logic watch(input int w);
    return (w == 0) ? overflow_irq_req : osc_out;
  endfunction : watch

  task wait_lvl(input int w, input logic lvl);
    int k;
    for (k = 0; k < 2000 && watch(w) !== lvl; k++) begin
      @(posedge hclk);
    end
    if (watch(w) !== lvl) begin
      fail_count++;
      results();
    end
  endtask : wait_lvl

  task span(input int w, input logic lvl, output int cnt);
    cnt = 0;
    while (watch(w) === lvl && cnt < 2000) begin
      @(posedge hclk);
      cnt++;
    end
  endtask : span

  // Second full gap between carry requests
  task irq_gap(output int gap);
    int w;
    wait_lvl(0, 1'b1);
    span(0, 1'b1, w);
    span(0, 1'b0, gap);
    span(0, 1'b1, w);
    check("irq width", w, 1);
    span(0, 1'b0, gap);
  endtask : irq_gap

  task set_inc(input logic [7:0] hi, input logic [7:0] lo);
    bus_write(OFF_INC_HIGH, hi);
    bus_write(OFF_INC_LOW, lo);
  endtask : set_inc

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    src_run = 3'h0;
    src_lvl = 3'h0;
    fail_count = 0;
    n_tests    = 0;
    offs  = '{OFF_CTRL, OFF_CLKSEL, OFF_ACC_LOW, OFF_ACC_HIGH, OFF_ACC_UPPER, OFF_INC_HIGH, OFF_INC_LOW, 8'h1c};
    rst_v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    one_v = '{8'h00, 8'he3, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h00};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and read-only or unused bits
    for (i = 0; i < 8; i++) rd_chk("reset value", offs[i], rst_v[i]);
    for (i = 1; i < 8; i++) bus_write(offs[i], 8'hff);
    for (i = 1; i < 8; i++) rd_chk("all ones", offs[i], one_v[i]);
    bus_write(OFF_CTRL, 8'h5f);
    @(posedge hclk);
    rd_chk("control", OFF_CTRL, 8'h71);
    repeat (2) @(posedge hclk);
    check("pin oe on", {31'h0, osc_pin_oe}, 32'h1);
    check("idle inverted", {31'h0, osc_out}, 32'h1);
    check("pin inverted", {31'h0, osc_pin_out}, 32'h1);
    bus_write(OFF_CTRL, 8'h00);
    repeat (2) @(posedge hclk);
    check("pin oe off", {31'h0, osc_pin_oe}, 32'h0);
    check("idle plain", {31'h0, osc_out}, 32'h0);
    check("pin plain", {31'h0, osc_pin_out}, 32'h0);
    // Toggle mode, system clock, pulse width field set but unused
    set_inc(8'h80, 8'h00);
    bus_write(OFF_CLKSEL, 8'he1);
    bus_write(OFF_CTRL, 8'h80);
    irq_gap(n);
    check("carry gap", n, 31);
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    span(1, 1'b1, n);
    check("toggle half", n, 32);
    bus_write(OFF_INC_HIGH, 8'h40);
    irq_gap(n);
    check("high only gap", n, 31);
    bus_write(OFF_INC_LOW, 8'h00);
    irq_gap(n);
    check("new inc gap", n, 63);
    set_inc(8'h80, 8'h00);
    // Slow sources: 32 ticks of 16 hclk each
    for (i = 0; i < 4; i++) begin
      if (i != 1) begin
        src_run <= (i == 0) ? 3'h1 : ((i == 2) ? 3'h2 : 3'h4);
        bus_write(OFF_CLKSEL, {6'h00, i[1:0]});
        irq_gap(n);
        check("source gap", n, 511);
      end
    end
    src_run <= 3'h0;
    // Pulse mode widths
    bus_write(OFF_CTRL, 8'h00);
    set_inc(8'h08, 8'h00);
    bus_write(OFF_CTRL, 8'h81);
    for (i = 0; i < 8; i++) begin
      bus_write(OFF_CLKSEL, {i[2:0], 5'h01});
      wait_lvl(1, 1'b0);
      wait_lvl(1, 1'b1);
      span(1, 1'b1, n);
      check("pulse width", n, 1 << i);
    end
    bus_write(OFF_CLKSEL, 8'h41);
    bus_write(OFF_CTRL, 8'h91);
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    span(1, 1'b0, n);
    check("low pulse", n, 4);
    // Disabled: no accumulation and no carry
    bus_write(OFF_CTRL, 8'h00);
    bus_write(OFF_ACC_LOW, 8'h12);
    span(0, 1'b0, n);
    check("no carry", n, 2000);
    rd_chk("held acc", OFF_ACC_LOW, 8'h12);
    check("off level", {31'h0, osc_out}, 32'h0);
    results();
  end
endmodule : tb_top
